// ===== verilog/reset_and_bootstrap_control.sv
// reset_and_bootstrap_control: core reset sequencing, test mode decode,
// bootstrap capture and the test multiplexer on the bootstrap lines
// assumes: all inputs synchronous to SYS_CLK, PCI_CLK is sampled as data,
// bootstrap pull-ups resolved on the board wire
//
// Functional notes
// - phy reset low while system reset low
// - core held 16348 clocks after system reset
// - core held 16348 pci clocks after pci reset
// - test mode pins decoded into four modes
// - normal mode samples bootstrap bus after reset
// - undriven bootstrap line reads as one
// - bits 10:8 set memory clock delay
// - bit 7 low bypasses pci pll
// - bit 6 low bypasses system pll
// - bit 5 sets management interrupt polarity
// - bit 4 low drives memory clock
// - bit 3 low enables freeze
// - bit 2 low shortens hold to 256
// - board test mode keeps core in reset
// - bit 10 picks board test variant
// - bootstrap lines carry test mux afterwards
// - memory clock output for test only
// - scan mode bypasses plls, resets follow pins
// - pll test mode holds core, opens plls
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module reset_and_bootstrap_control #(
  parameter int HOLD_CYCLES = reset_boot_pkg::HOLD_NORMAL
) (
  // system clock and resets
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PCI_CLK,
  input  wire logic        PCI_RST_N,
  // test mode and bootstrap lines
  input  wire logic [1:0]  T_MODE,
  input  wire logic [15:0] T_D_IN,
  output logic      [15:0] T_D_OUT,
  output logic             T_D_OE_N,
  // resets out
  output logic             PHY_RESET_N,
  output logic             CORE_SYS_RESET_N,
  output logic             CORE_PCI_RESET_N,
  // configuration out
  output logic      [2:0]  MEM_CLK_DELAY,
  output logic             PCI_PLL_BYPASS,
  output logic             SYS_PLL_BYPASS,
  output logic             FREEZE_EN,
  output logic             BOARD_TEST_VARIANT,
  output logic             PLL_TEST_ACCESS,
  // memory clock pin
  output logic             MEM_CLK_OUT,
  output logic             MEM_CLK_OE_N,
  // management interrupts
  input  wire logic        INT_A_REQ,
  input  wire logic        INT_B_REQ,
  output logic             MANAGEMENT_INTERRUPT_A,
  output logic             MANAGEMENT_INTERRUPT_B,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O
);

  // -------------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------------
  function automatic logic [14:0] hold_limit(input logic fast_n);
    hold_limit = fast_n ? 15'(HOLD_CYCLES) : 15'(reset_boot_pkg::HOLD_FAST);
  endfunction

  function automatic logic mode_is(input logic [1:0] m, input logic [1:0] c);
    mode_is = (m == c);
  endfunction

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  reset_boot_pkg::seq_t seq_r;
  logic [1:0]  mode_r;
  logic        mode_taken_r;
  logic [3:0]  smp_cnt_r;
  logic [15:0] boot_r;
  logic [14:0] sys_cnt_r;
  logic [14:0] pci_cnt_r;
  logic        pci_clk_q_r;
  logic        pci_edge;
  logic        sampled;
  logic        normal;
  logic        scan;
  logic        mux_src_r;
  logic [15:0] testdat_r;
  logic [31:0] status;
  logic        wb_req;
  logic        wb_wr;

  assign sampled  = (seq_r != reset_boot_pkg::SEQ_SAMPLE);
  assign normal   = mode_is(mode_r, reset_boot_pkg::MODE_NORMAL);
  assign scan     = mode_is(mode_r, reset_boot_pkg::MODE_SCAN);
  assign pci_edge = PCI_CLK & ~pci_clk_q_r;
  assign wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr    = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

  // -------------------------------------------------------------------------
  // phy reset
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PHY_RESET_N <= 1'b0;
    end else begin
      PHY_RESET_N <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // test mode capture at reset release
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r       <= reset_boot_pkg::MODE_NORMAL;
      mode_taken_r <= 1'b0;
    end else if (!mode_taken_r) begin
      mode_r       <= T_MODE;
      mode_taken_r <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // bootstrap sampling and system hold sequence
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_r     <= reset_boot_pkg::SEQ_SAMPLE;
      smp_cnt_r <= 4'h0;
      boot_r    <= reset_boot_pkg::BOOT_RESET;
      sys_cnt_r <= 15'h0000;
    end else begin
      case (seq_r)
        reset_boot_pkg::SEQ_SAMPLE: begin
          if (smp_cnt_r == 4'(reset_boot_pkg::SAMPLE_CYC)) begin
            boot_r <= T_D_IN;
            seq_r  <= reset_boot_pkg::SEQ_HOLD;
          end else begin
            smp_cnt_r <= smp_cnt_r + 4'h1;
          end
        end
        reset_boot_pkg::SEQ_HOLD: begin
          if (sys_cnt_r == hold_limit(boot_r[reset_boot_pkg::BT_FAST_N])) begin
            seq_r <= reset_boot_pkg::SEQ_RUN;
          end else begin
            sys_cnt_r <= sys_cnt_r + 15'h0001;
          end
        end
        reset_boot_pkg::SEQ_RUN: begin
          seq_r <= reset_boot_pkg::SEQ_RUN;
        end
        default: begin
          seq_r <= reset_boot_pkg::SEQ_SAMPLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // core system reset
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CORE_SYS_RESET_N <= 1'b0;
    end else if (!mode_taken_r) begin
      CORE_SYS_RESET_N <= 1'b0;
    end else if (scan) begin
      CORE_SYS_RESET_N <= 1'b1;
    end else if (normal) begin
      CORE_SYS_RESET_N <= (seq_r == reset_boot_pkg::SEQ_RUN);
    end else begin
      CORE_SYS_RESET_N <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // pci hold counter and core pci reset
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge PCI_RST_N) begin
    if (!PCI_RST_N) begin
      pci_clk_q_r      <= 1'b1;
      pci_cnt_r        <= 15'h0000;
      CORE_PCI_RESET_N <= 1'b0;
    end else begin
      pci_clk_q_r <= PCI_CLK;
      if (sampled && pci_edge &&
          pci_cnt_r != hold_limit(boot_r[reset_boot_pkg::BT_FAST_N])) begin
        pci_cnt_r <= pci_cnt_r + 15'h0001;
      end
      if (scan && mode_taken_r) begin
        CORE_PCI_RESET_N <= 1'b1;
      end else if (normal && sampled) begin
        CORE_PCI_RESET_N <=
          (pci_cnt_r == hold_limit(boot_r[reset_boot_pkg::BT_FAST_N]));
      end else begin
        CORE_PCI_RESET_N <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // configuration outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MEM_CLK_DELAY      <= 3'h7;
      PCI_PLL_BYPASS     <= 1'b0;
      SYS_PLL_BYPASS     <= 1'b0;
      FREEZE_EN          <= 1'b0;
      BOARD_TEST_VARIANT <= 1'b0;
      PLL_TEST_ACCESS    <= 1'b0;
    end else begin
      MEM_CLK_DELAY <= boot_r[reset_boot_pkg::BT_DLY_LO +:
                              reset_boot_pkg::BT_DLY_W];
      PCI_PLL_BYPASS <= (mode_taken_r && scan) ||
        (sampled && normal && !boot_r[reset_boot_pkg::BT_PCI_BYP_N]);
      SYS_PLL_BYPASS <= (mode_taken_r && scan) ||
        (sampled && normal && !boot_r[reset_boot_pkg::BT_SYS_BYP_N]);
      FREEZE_EN <= sampled && normal &&
        !boot_r[reset_boot_pkg::BT_FREEZE_N];
      BOARD_TEST_VARIANT <= mode_is(mode_r, reset_boot_pkg::MODE_BOARD) &&
        boot_r[reset_boot_pkg::BT_BOARD_SEL];
      PLL_TEST_ACCESS <= mode_taken_r &&
        mode_is(mode_r, reset_boot_pkg::MODE_PLL);
    end
  end

  // -------------------------------------------------------------------------
  // memory clock pin
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MEM_CLK_OUT  <= 1'b0;
      MEM_CLK_OE_N <= 1'b1;
    end else begin
      MEM_CLK_OUT  <= ~MEM_CLK_OUT;
      MEM_CLK_OE_N <= !(sampled && normal &&
        !boot_r[reset_boot_pkg::BT_MCLK_EN_N]);
    end
  end

  // -------------------------------------------------------------------------
  // management interrupt polarity
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MANAGEMENT_INTERRUPT_A <= 1'b0;
      MANAGEMENT_INTERRUPT_B <= 1'b0;
    end else begin
      MANAGEMENT_INTERRUPT_A <=
        INT_A_REQ ~^ boot_r[reset_boot_pkg::BT_INT_POL];
      MANAGEMENT_INTERRUPT_B <=
        INT_B_REQ ~^ boot_r[reset_boot_pkg::BT_INT_POL];
    end
  end

  // -------------------------------------------------------------------------
  // test multiplexer on the bootstrap lines
  // -------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      T_D_OUT  <= 16'h0000;
      T_D_OE_N <= 1'b1;
    end else begin
      T_D_OE_N <= !sampled;
      T_D_OUT  <= mux_src_r ? testdat_r : status[15:0];
    end
  end

  // -------------------------------------------------------------------------
  // wishbone registers
  // -------------------------------------------------------------------------
  assign status = {11'h000, CORE_PCI_RESET_N, CORE_SYS_RESET_N, sampled,
                   mode_r, boot_r};

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mux_src_r <= 1'b0;
      testdat_r <= reset_boot_pkg::TESTDAT_RESET;
    end else if (wb_wr) begin
      if (WB_ADR_I == reset_boot_pkg::ADR_CONTROL && WB_SEL_I[0]) begin
        mux_src_r <= WB_DAT_I[reset_boot_pkg::CT_MUX_SRC];
      end
      if (WB_ADR_I == reset_boot_pkg::ADR_TESTDAT) begin
        if (WB_SEL_I[0]) begin
          testdat_r[7:0] <= WB_DAT_I[7:0];
        end
        if (WB_SEL_I[1]) begin
          testdat_r[15:8] <= WB_DAT_I[15:8];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      case (WB_ADR_I)
        reset_boot_pkg::ADR_STATUS:  WB_DAT_O <= status;
        reset_boot_pkg::ADR_CONTROL: WB_DAT_O <= {31'h00000000, mux_src_r};
        reset_boot_pkg::ADR_TESTDAT: WB_DAT_O <= {16'h0000, testdat_r};
        default:                     WB_DAT_O <= 32'h00000000;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  property p_phy_high;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $past(PHY_RESET_N) |-> PHY_RESET_N;
  endproperty
  a_phy_high: assert property (p_phy_high)
    else $error("phy reset dropped without system reset");

  property p_sys_hold;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (normal && CORE_SYS_RESET_N) |->
      sys_cnt_r == hold_limit(boot_r[reset_boot_pkg::BT_FAST_N]);
  endproperty
  a_sys_hold: assert property (p_sys_hold)
    else $error("core system reset released before hold count");

  property p_pci_hold;
    @(posedge SYS_CLK) disable iff (!PCI_RST_N || !RESET_N)
    (normal && CORE_PCI_RESET_N) |->
      $past(pci_cnt_r) == hold_limit(boot_r[reset_boot_pkg::BT_FAST_N]);
  endproperty
  a_pci_hold: assert property (p_pci_hold)
    else $error("core pci reset released before hold count");

  property p_fast_limit;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (normal && CORE_SYS_RESET_N && !boot_r[reset_boot_pkg::BT_FAST_N]) |->
      sys_cnt_r == 15'(reset_boot_pkg::HOLD_FAST);
  endproperty
  a_fast_limit: assert property (p_fast_limit)
    else $error("speed-up hold length wrong");

  property p_board_hold;
    @(posedge SYS_CLK) disable iff (!RESET_N || !PCI_RST_N)
    (mode_taken_r && !normal && !scan) |=> !CORE_SYS_RESET_N
      && !CORE_PCI_RESET_N;
  endproperty
  a_board_hold: assert property (p_board_hold)
    else $error("core left reset in board or pll test mode");

  property p_pll_access;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (mode_taken_r && mode_is(mode_r, reset_boot_pkg::MODE_PLL))
      |=> PLL_TEST_ACCESS;
  endproperty
  a_pll_access: assert property (p_pll_access)
    else $error("pll test access not given");

  property p_scan;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (mode_taken_r && scan) |=> SYS_PLL_BYPASS && PCI_PLL_BYPASS
      && CORE_SYS_RESET_N;
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan mode not applied");

  property p_boot_stable;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (sampled && $past(sampled)) |-> $stable(boot_r);
  endproperty
  a_boot_stable: assert property (p_boot_stable)
    else $error("bootstrap latch changed after sampling");

  property p_mux_drive;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    sampled |=> !T_D_OE_N;
  endproperty
  a_mux_drive: assert property (p_mux_drive)
    else $error("test mux not driven after sampling");

  property p_pci_bypass;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (sampled && normal && !boot_r[reset_boot_pkg::BT_PCI_BYP_N])
      |=> PCI_PLL_BYPASS;
  endproperty
  a_pci_bypass: assert property (p_pci_bypass)
    else $error("pci pll bypass not set");

endmodule

`default_nettype wire

// ===== verilog/reset_boot_pkg.sv
// reset_boot_pkg: constants for the reset and bootstrap control block
// assumes: one 25 MHz system clock, 32-bit classic wishbone register bus
`default_nettype none
package reset_boot_pkg;

  // -------------------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SAMPLE_DELAY_NS = 160;
  localparam int SAMPLE_CYC      =
    (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SMP_W           = 4;
  localparam int HOLD_W          = 15;
  localparam int HOLD_NORMAL     = 16348;
  localparam int HOLD_FAST       = 256;
  localparam int MEM_CLK_MHZ     = 66;

  // -------------------------------------------------------------------------
  // test mode codes
  // -------------------------------------------------------------------------
  localparam logic [1:0] MODE_PLL    = 2'h0;
  localparam logic [1:0] MODE_SCAN   = 2'h1;
  localparam logic [1:0] MODE_BOARD  = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  // -------------------------------------------------------------------------
  // bootstrap field positions
  // -------------------------------------------------------------------------
  localparam int BOOT_W        = 16;
  localparam int BT_DLY_LO     = 8;
  localparam int BT_DLY_W      = 3;
  localparam int BT_BOARD_SEL  = 10;
  localparam int BT_PCI_BYP_N  = 7;
  localparam int BT_SYS_BYP_N  = 6;
  localparam int BT_INT_POL    = 5;
  localparam int BT_MCLK_EN_N  = 4;
  localparam int BT_FREEZE_N   = 3;
  localparam int BT_FAST_N     = 2;
  localparam logic [15:0] BOOT_RESET = 16'hFFFF;

  // -------------------------------------------------------------------------
  // register map (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [3:0] ADR_STATUS  = 4'h0;
  localparam logic [3:0] ADR_CONTROL = 4'h4;
  localparam logic [3:0] ADR_TESTDAT = 4'h8;
  localparam int ST_MODE_LO   = 16;
  localparam int ST_SAMPLED   = 18;
  localparam int ST_CORE_SYS  = 19;
  localparam int ST_CORE_PCI  = 20;
  localparam int CT_MUX_SRC   = 0;
  localparam logic [15:0] TESTDAT_RESET = 16'h0000;

  // -------------------------------------------------------------------------
  // system-side sequence states
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_SAMPLE = 3'b001,
    SEQ_HOLD   = 3'b010,
    SEQ_RUN    = 3'b100
  } seq_t;

endpackage

`default_nettype wire

// ===== dv/board_strap_model.sv
// board_strap_model: board side of the reset and bootstrap block
// assumes: bench sets the strap mask and the pci reset level
`timescale 1ns/10ps
`default_nettype none

module board_strap_model (
  // strap and test mux wire
  input  wire logic [15:0] pull_down,
  input  wire logic [15:0] t_d_out,
  input  wire logic        t_d_oe_n,
  output logic      [15:0] t_d_in,
  // pci clock and reset
  input  wire logic        pci_rst_n,
  output logic             pci_clk,
  output int               pci_edges,
  // board-held test inputs
  output logic             scan_port_rst_n,
  output logic             quiet_test_en
);
  // boundary scan reset and quiescent current test held low
  assign scan_port_rst_n = 1'b0;
  assign quiet_test_en   = 1'b0;

  // ------------------------------------------------------------------
  // wire resolution
  // ------------------------------------------------------------------
  // open lines float high, bit 14 always strapped low
  assign t_d_in = t_d_oe_n ? ~(pull_down | 16'h4000) :
                  t_d_out;

  // ------------------------------------------------------------------
  // free running pci clock, 200 ns
  // ------------------------------------------------------------------
  initial begin
    pci_clk = 1'b0;
    // offset keeps pci edges off system clock edges
    #10;
    forever #100 pci_clk = ~pci_clk;
  end

  // pci edges since pci reset release
  always_ff @(posedge pci_clk or negedge pci_rst_n) begin
    if (!pci_rst_n) begin
      pci_edges <= 0;
    end else begin
      pci_edges <= pci_edges + 1;
    end
  end
endmodule

`default_nettype wire

// ===== dv/tb_reset_and_bootstrap_control.sv
// tb_reset_and_bootstrap_control: self-checking bench of the reset block
// assumes: board_strap_model gives straps, pci clock and wire level
`timescale 1ns/10ps
`default_nettype none

module tb_reset_and_bootstrap_control;
  // ------------------------------------------------------------------
  // settings and case table
  // ------------------------------------------------------------------
  localparam int H = 40;
  localparam logic [1:0] NRM = reset_boot_pkg::MODE_NORMAL;
  localparam logic [1:0] SCN = reset_boot_pkg::MODE_SCAN;
  localparam logic [1:0] BRD = reset_boot_pkg::MODE_BOARD;
  localparam logic [1:0] PLT = reset_boot_pkg::MODE_PLL;
  // fl: pci byp, sys byp, freeze, mclk oe_n, board variant, pll access
  // kind: 0 full hold, 1 short hold, 2 follows pins, 3 stays in reset
  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] pd;
    logic [2:0]  dly;
    logic [5:0]  fl;
    logic [1:0]  kind;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{NRM, 16'h0000, 3'h7, 6'h04, 2'h0},
    '{NRM, 16'h0080, 3'h7, 6'h24, 2'h0},
    '{NRM, 16'h0040, 3'h7, 6'h14, 2'h0},
    '{NRM, 16'h0018, 3'h7, 6'h08, 2'h0},
    '{NRM, 16'h0524, 3'h2, 6'h04, 2'h1},
    '{SCN, 16'h0000, 3'h7, 6'h34, 2'h2},
    '{BRD, 16'h0400, 3'h7, 6'h04, 2'h3},
    '{BRD, 16'h0000, 3'h7, 6'h06, 2'h3},
    '{PLT, 16'h0000, 3'h7, 6'h05, 2'h3}
  };

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        SYS_CLK, RESET_N, PCI_CLK, PCI_RST_N, T_D_OE_N;
  logic        PHY_RESET_N, CORE_SYS_RESET_N, CORE_PCI_RESET_N;
  logic        PCI_PLL_BYPASS, SYS_PLL_BYPASS, FREEZE_EN, PLL_TEST_ACCESS;
  logic        BOARD_TEST_VARIANT, MEM_CLK_OUT, MEM_CLK_OE_N;
  logic        INT_A_REQ, INT_B_REQ, MGT_A, MGT_B, a;
  logic        WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [1:0]  T_MODE;
  logic [2:0]  MEM_CLK_DELAY;
  logic [3:0]  WB_ADR_I, WB_SEL_I;
  logic [15:0] T_D_IN, T_D_OUT, pull_down;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  int          fails, n_tests, n, lim, pci_n;
  row_t        r;

  reset_and_bootstrap_control #(
    .HOLD_CYCLES(H)
  ) reset_and_bootstrap_control_inst (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PCI_CLK(PCI_CLK),
    .PCI_RST_N(PCI_RST_N), .T_MODE(T_MODE), .T_D_IN(T_D_IN),
    .T_D_OUT(T_D_OUT), .T_D_OE_N(T_D_OE_N), .PHY_RESET_N(PHY_RESET_N),
    .CORE_SYS_RESET_N(CORE_SYS_RESET_N), .CORE_PCI_RESET_N(CORE_PCI_RESET_N),
    .MEM_CLK_DELAY(MEM_CLK_DELAY), .PCI_PLL_BYPASS(PCI_PLL_BYPASS),
    .SYS_PLL_BYPASS(SYS_PLL_BYPASS), .FREEZE_EN(FREEZE_EN),
    .BOARD_TEST_VARIANT(BOARD_TEST_VARIANT),
    .PLL_TEST_ACCESS(PLL_TEST_ACCESS), .MEM_CLK_OUT(MEM_CLK_OUT),
    .MEM_CLK_OE_N(MEM_CLK_OE_N), .INT_A_REQ(INT_A_REQ),
    .INT_B_REQ(INT_B_REQ), .MANAGEMENT_INTERRUPT_A(MGT_A),
    .MANAGEMENT_INTERRUPT_B(MGT_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O)
  );

  board_strap_model board_strap_model_inst (
    .pull_down(pull_down), .t_d_out(T_D_OUT), .t_d_oe_n(T_D_OE_N),
    .t_d_in(T_D_IN), .pci_rst_n(PCI_RST_N), .pci_clk(PCI_CLK),
    .pci_edges(pci_n), .scan_port_rst_n(), .quiet_test_en()
  );

  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic results();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic do_reset(input logic [1:0] md, input logic [15:0] pd);
    @(posedge SYS_CLK);
    RESET_N <= 1'b0;
    PCI_RST_N <= 1'b0;
    T_MODE <= md;
    pull_down <= pd;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk({PHY_RESET_N, CORE_SYS_RESET_N, CORE_PCI_RESET_N, T_D_OE_N,
         MEM_CLK_OE_N, MEM_CLK_DELAY} === 8'h1F, "reset levels");
    @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    PCI_RST_N <= 1'b1;
  endtask

  // wait for a core reset release: 0 system side, 1 pci side
  task automatic wt(input int sel, input int bound, output int cnt);
    for (cnt = 1; cnt <= bound; cnt++) begin
      @(posedge SYS_CLK);
      #1;
      if ((sel == 0 ? CORE_SYS_RESET_N : CORE_PCI_RESET_N) === 1'b1) return;
    end
    chk(1'b0, "wait ran out");
    results();
  endtask

  task automatic pci_chk(input int l);
    wt(1, l * 8 + 100, n);
    chk(pci_n >= l && pci_n <= l + 4, "pci hold length");
  endtask

  task automatic wb(input logic we, input logic [3:0] ad,
                    input logic [31:0] d, output logic [31:0] rd);
    int k;
    @(posedge SYS_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= ad;
    WB_DAT_I <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge SYS_CLK);
      if (WB_ACK_O === 1'b1) break;
    end
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (k == 20) begin
      chk(1'b0, "no bus ack");
      results();
    end
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {RESET_N, PCI_RST_N, WB_CYC_I, WB_STB_I, WB_WE_I} = 5'h00;
    {INT_A_REQ, INT_B_REQ, T_MODE} = 4'hB;
    {WB_ADR_I, WB_DAT_I, pull_down} = 52'h0;
    WB_SEL_I = 4'hF;
    fails = 0;
    n_tests = 0;
    for (int i = 0; i < 9; i++) begin
      r = ROWS[i];
      do_reset(r.mode, r.pd);
      lim = r.kind == 2'h0 ? H :
            r.kind == 2'h1 ? reset_boot_pkg::HOLD_FAST : 4;
      if (r.kind == 2'h3) begin
        repeat (400) @(posedge SYS_CLK);
        #1;
        chk(!CORE_SYS_RESET_N && !CORE_PCI_RESET_N,
            "core left reset");
      end else begin
        wt(0, lim + 12, n);
      end
      if (r.kind < 2'h2) begin
        chk(n >= lim && n <= lim + 10, "system hold length");
      end
      if (r.kind == 2'h2) begin
        chk(n <= 4 && CORE_PCI_RESET_N === 1'b1, "scan resets");
        repeat (8) @(posedge SYS_CLK);
        #1;
      end
      chk({PCI_PLL_BYPASS, SYS_PLL_BYPASS} === r.fl[5:4],
          "bypass");
      chk({FREEZE_EN, MEM_CLK_OE_N} === r.fl[3:2],
          "freeze and clock enable");
      chk({BOARD_TEST_VARIANT, PLL_TEST_ACCESS} === r.fl[1:0],
          "test outputs");
      chk(T_D_OE_N === 1'b0 && PHY_RESET_N === 1'b1, "pins after");
      if (r.mode == NRM) begin
        chk(MEM_CLK_DELAY === r.dly, "clock delay");
        chk(MGT_A === ~r.pd[5] && MGT_B === r.pd[5], "irq level");
        pci_chk(lim);
      end
      $display("row %0d done", i);
    end
    do_reset(NRM, 16'h0010);
    wt(0, H + 12, n);
    a = MEM_CLK_OUT;
    @(posedge SYS_CLK);
    #1;
    chk(MEM_CLK_OUT === ~a && MEM_CLK_OE_N === 1'b0, "mem clock");
    wb(1'b0, reset_boot_pkg::ADR_STATUS, 32'h0, q);
    chk(q[18:0] === {1'b1, NRM, 16'hBFEF}, "status");
    pull_down <= 16'hFFFF;
    T_MODE <= SCN;
    repeat (5) @(posedge SYS_CLK);
    wb(1'b0, reset_boot_pkg::ADR_STATUS, 32'h0, q);
    chk(q[17:0] === {NRM, 16'hBFEF} && !MEM_CLK_OE_N,
        "latch kept");
    chk(T_D_IN === 16'hBFEF, "status on pins");
    $display("latch test done");
    wb(1'b1, reset_boot_pkg::ADR_CONTROL, 32'h1, q);
    wb(1'b1, reset_boot_pkg::ADR_TESTDAT, 32'h5AC3, q);
    wb(1'b0, reset_boot_pkg::ADR_TESTDAT, 32'h0, q);
    chk(q[15:0] === 16'h5AC3, "testdat readback");
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk(T_D_IN === 16'h5AC3, "test mux on pins");
    wb(1'b0, 4'hC, 32'h0, q);
    chk(q === 32'h0, "unmapped read");
    $display("bus test done");
    pci_chk(H);
    PCI_RST_N <= 1'b0;
    #1;
    chk(!CORE_PCI_RESET_N && CORE_SYS_RESET_N, "pci reset");
    @(posedge SYS_CLK);
    PCI_RST_N <= 1'b1;
    pci_chk(H);
    $display("pci reset test done");
    results();
  end
endmodule

`default_nettype wire
